// File: rtl/stc_map.vh
/*
 Register map and timing constants for the sleep timing configuration block.
 Assumes a 125 MHz clock and a 32-bit APB register bus.
*/
`ifndef STC_MAP_VH
`define STC_MAP_VH
`define STC_ADDR_WP 12'h024
`define STC_ADDR_SLP1 12'h028
`define STC_ADDR_ETM 12'h02C
`define STC_ADDR_CTRL 12'h040
`define STC_ADDR_STAT 12'h044
`define STC_IDX_WP 8'h09
`define STC_IDX_SLP1 8'h0A
`define STC_IDX_ETM 8'h0B
`define STC_WP_OPEN 8'h5A
`define STC_WP_RST 8'h00
`define STC_SLP1_RST 8'h72
`define STC_ETM_RST 8'h10
`define STC_FLD_HI 7
`define STC_FLD_LO 4
`define STC_DFLD_HI 3
`define STC_DFLD_LO 0
`define STC_CTRL_RST 1'h1
`define STC_CLK_MHZ 125
`define STC_POLL_STEP_MS 4
`define STC_L_ENTRY_STEP_MS 128
`define STC_D_ENTRY_STEP_MS 20480
`define STC_PH_NORMAL 3'h0
`define STC_PH_ENTER_L 3'h1
`define STC_PH_ENTER_D 3'h2
`define STC_PH_ASLEEP 3'h4
`endif

// File: rtl/stc_tick.v
/*
 Step tick generator: one pulse every step_cycles clocks while running.
 Assumes a synchronous, already released reset.
*/
`timescale 1ns/1ps
`default_nettype none
module stc_tick #(
   parameter [31:0] STEP_CYCLES = 32'h0000_0010
) (
   input wire clk,
   input wire rst_n,
   input wire run,
   output reg tick
);
   reg [31:0] cnt_r;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= 32'h0;
         tick <= 1'b0;
      end else if (!run) begin
         cnt_r <= 32'h0;
         tick <= 1'b0;
      end else if (cnt_r >= STEP_CYCLES - 32'h1) begin
         cnt_r <= 32'h0;
         tick <= 1'b1;
      end else begin
         cnt_r <= cnt_r + 32'h1;
         tick <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// File: rtl/stc_top.v
/*
 Sleep timing configuration: APB registers, light/deep sleep entry and
 periodic wake polling. Assumes motion is reported by a level input.
*/
`timescale 1ns/1ps
`default_nettype none
`include "stc_map.vh"
// Behaviour
// [R1] In light sleep, wake periodically for a motion check using the upper nibble interval.
// [R2] Poll interval code n gives (n+1) times 4 ms.
// [R3] Poll interval field resets to 0111, a 32 ms interval.
// [R4] Light sleep entry delay from upper nibble, 128 ms steps, reset code 0001.
// [R5] Software writes 0010 into the low nibble of the poll setting register.
// [R6] Registers 0x0A upward are writable only while write protect holds 0x5A; the code guards only 0x0A and 0x0B, and CTRL writes always land.
// [R7] Phase reported as 3-bit code plus a bit telling light from deep sleep.
module stc_top #(
   parameter [31:0] POLL_STEP_CYC = `STC_POLL_STEP_MS * 32'h0000_03E8 * `STC_CLK_MHZ,
   parameter [31:0] L_ENTRY_STEP_CYC = `STC_L_ENTRY_STEP_MS * 32'h0000_03E8 * `STC_CLK_MHZ,
   parameter [31:0] D_ENTRY_STEP_CYC = `STC_D_ENTRY_STEP_MS * 32'h0000_03E8 * `STC_CLK_MHZ
) (
   input wire ref_clk,
   input wire rstn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire motion,
   output reg [2:0] operation_phase,
   output reg deep_sleep,
   output reg poll_wake,
   output reg wake_event
);
   localparam [3:0] S_NORM = 4'h1;
   localparam [3:0] S_ENT_L = 4'h2;
   localparam [3:0] S_ENT_D = 4'h4;
   localparam [3:0] S_SLEEP = 4'h8;

   reg rst_s1_r;
   reg rst_n_r;
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rst_s1_r <= 1'b0;
         rst_n_r <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n_r <= rst_s1_r;
      end
   end

   reg [7:0] wp_r;
   reg [7:0] slp1_r;
   reg [7:0] etm_r;
   reg sleep_en_r;
   reg [3:0] st_r;
   reg deep_r;
   reg [3:0] step_r;
   reg [31:0] rd_nxt;
   // First access-phase cycle; the answer follows one cycle later
   wire access = psel & penable & ~pready;
   // Writes land on the edge at which the master sees pready high
   wire commit = psel & penable & pready & pwrite;
   wire sel_wp = (paddr == `STC_ADDR_WP);
   wire sel_slp1 = (paddr == `STC_ADDR_SLP1);
   wire sel_etm = (paddr == `STC_ADDR_ETM);
   wire sel_ctrl = (paddr == `STC_ADDR_CTRL);
   wire sel_stat = (paddr == `STC_ADDR_STAT);
   wire sel_prot = sel_slp1 | sel_etm;
   wire hit = sel_wp | sel_prot | sel_ctrl | sel_stat;
   wire wp_open = (wp_r == `STC_WP_OPEN);
   wire [3:0] poll_code = slp1_r[`STC_FLD_HI:`STC_FLD_LO];
   wire [3:0] l_code = etm_r[`STC_FLD_HI:`STC_FLD_LO];
   wire [3:0] d_code = etm_r[`STC_DFLD_HI:`STC_DFLD_LO];
   wire run_poll = (st_r == S_SLEEP) & ~deep_r;
   wire run_l = (st_r == S_ENT_L);
   wire run_d = (st_r == S_ENT_D);
   wire t_poll;
   wire t_l;
   wire t_d;

   stc_tick #(
      .STEP_CYCLES(POLL_STEP_CYC)
   ) u_poll (
      .clk(ref_clk),
      .rst_n(rst_n_r),
      .run(run_poll),
      .tick(t_poll)
   );
   stc_tick #(
      .STEP_CYCLES(L_ENTRY_STEP_CYC)
   ) u_lent (
      .clk(ref_clk),
      .rst_n(rst_n_r),
      .run(run_l),
      .tick(t_l)
   );
   stc_tick #(
      .STEP_CYCLES(D_ENTRY_STEP_CYC)
   ) u_dent (
      .clk(ref_clk),
      .rst_n(rst_n_r),
      .run(run_d),
      .tick(t_d)
   );

   // Read data of the addressed register; unmapped reads give zero
   always @* begin
      rd_nxt = 32'h0000_0000;
      case (paddr)
         `STC_ADDR_WP: rd_nxt = {24'h00_0000, wp_r};
         `STC_ADDR_SLP1: rd_nxt = {24'h00_0000, slp1_r};
         `STC_ADDR_ETM: rd_nxt = {24'h00_0000, etm_r};
         `STC_ADDR_CTRL: rd_nxt = {31'h0000_0000, sleep_en_r};
         `STC_ADDR_STAT: rd_nxt = {28'h000_0000, deep_sleep, operation_phase}; // see [R7]
         default: rd_nxt = 32'h0000_0000;
      endcase
   end

   // Bus answer, one wait state; protected writes are dropped with an error
   always @(posedge ref_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= access;
         pslverr <= 1'b0;
         if (access) begin
            prdata <= rd_nxt;
            pslverr <= ~hit | (pwrite & sel_prot & ~wp_open); // see [R6]
         end
      end
   end

   // Register storage
   always @(posedge ref_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         wp_r <= `STC_WP_RST;
         slp1_r <= `STC_SLP1_RST; // see [R3]
         etm_r <= `STC_ETM_RST; // see [R4]
         sleep_en_r <= `STC_CTRL_RST;
      end else if (commit) begin
         if (sel_wp) wp_r <= pwdata[7:0];
         if (sel_slp1 && wp_open) slp1_r <= pwdata[7:0]; // see [R6]
         if (sel_etm && wp_open) etm_r <= pwdata[7:0]; // see [R6]
         if (sel_ctrl) sleep_en_r <= pwdata[0];
      end
   end

   // Sleep phase machine; each step counts code+1 ticks
   always @(posedge ref_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         st_r <= S_NORM;
         deep_r <= 1'b0;
         step_r <= 4'h0;
         poll_wake <= 1'b0;
         wake_event <= 1'b0;
      end else begin
         poll_wake <= 1'b0;
         wake_event <= 1'b0;
         case (st_r)
            S_NORM: begin
               step_r <= 4'h0;
               deep_r <= 1'b0;
               if (sleep_en_r && !motion) st_r <= S_ENT_L;
            end
            S_ENT_L: begin
               if (motion || !sleep_en_r) st_r <= S_NORM;
               else if (t_l) begin
                  if (step_r == l_code) begin // see [R4]
                     st_r <= S_SLEEP;
                     step_r <= 4'h0;
                  end else step_r <= step_r + 4'h1;
               end
            end
            S_SLEEP: begin
               if (!deep_r && t_poll) begin
                  if (step_r == poll_code) begin // see [R1] [R2]
                     step_r <= 4'h0;
                     poll_wake <= 1'b1;
                     if (motion) begin
                        st_r <= S_NORM;
                        wake_event <= 1'b1;
                     end else st_r <= S_ENT_D;
                  end else step_r <= step_r + 4'h1;
               end else if (deep_r && motion) begin
                  st_r <= S_NORM;
                  wake_event <= 1'b1;
               end
            end
            S_ENT_D: begin
               if (motion) begin
                  st_r <= S_NORM;
                  wake_event <= 1'b1;
               end else if (t_d) begin
                  if (step_r == d_code) begin
                     st_r <= S_SLEEP;
                     deep_r <= 1'b1;
                     step_r <= 4'h0;
                  end else step_r <= step_r + 4'h1;
               end
            end
            default: st_r <= S_NORM;
         endcase
      end
   end

   // Phase output, registered
   always @(posedge ref_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         operation_phase <= `STC_PH_NORMAL;
         deep_sleep <= 1'b0;
      end else begin
         deep_sleep <= deep_r; // see [R7]
         case (st_r)
            S_ENT_L: operation_phase <= `STC_PH_ENTER_L;
            S_ENT_D: operation_phase <= `STC_PH_ENTER_D;
            S_SLEEP: operation_phase <= `STC_PH_ASLEEP;
            default: operation_phase <= `STC_PH_NORMAL;
         endcase
      end
   end
endmodule
`default_nettype wire

// File: testbench/stc_top_asserts.sv
/* Checker for the sleep timing block ports.
 Assumes the bench uses a poll step of at least 8 clocks. */
`timescale 1ns/1ps
`default_nettype none
module stc_top_asserts (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [2:0] operation_phase,
   input wire logic deep_sleep,
   input wire logic poll_wake,
   input wire logic wake_event
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   property p_code; operation_phase inside {3'h0, 3'h1, 3'h2, 3'h4}; endproperty
   a_code: assert property (p_code) else $error("bad phase code");
   property p_deep; deep_sleep |-> operation_phase == 3'h4 || $past(operation_phase) == 3'h4;
   endproperty
   a_deep: assert property (p_deep) else $error("deep flag outside sleep");
   property p_poll; poll_wake |-> !deep_sleep && $past(operation_phase) == 3'h4; endproperty
   a_poll: assert property (p_poll) else $error("poll outside light sleep");
   property p_gap; poll_wake |=> !poll_wake [*7]; endproperty
   a_gap: assert property (p_gap) else $error("polls too close");
   property p_entry; $past(operation_phase) == 3'h0 |-> operation_phase inside {3'h0, 3'h1};
   endproperty
   a_entry: assert property (p_entry) else $error("skipped light entry");
   property p_err; pslverr |-> pready; endproperty
   a_err: assert property (p_err) else $error("error without ready");
   property p_wake; wake_event |=> operation_phase == 3'h0; endproperty
   a_wake: assert property (p_wake) else $error("no return to normal after wake");
   c_poll: cover property (poll_wake);
   c_wake: cover property (wake_event);
   c_err: cover property (pslverr);
   c_deep: cover property (deep_sleep && operation_phase == 3'h4);
endmodule
bind stc_top stc_top_asserts stc_top_asserts_i (.ref_clk(ref_clk), .rstn(rstn),
   .pready(pready), .pslverr(pslverr), .operation_phase(operation_phase),
   .deep_sleep(deep_sleep), .poll_wake(poll_wake), .wake_event(wake_event));
`default_nettype wire

// File: testbench/stc_apb_host.sv
/* APB master standing for the mouse controller.
 Assumes the caller checks the returned data and timeout count. */
`timescale 1ns/1ps
`default_nettype none
module stc_apb_host (
   input wire logic ref_clk,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [31:0] prdata,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata
);
   int to;
   initial {psel, penable, pwrite, paddr, pwdata} = '0;
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] rd, output logic err);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      to = 0;
      do @(posedge ref_clk); while (pready !== 1'b1 && ++to < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~d;
   endtask
endmodule
`default_nettype wire

// File: testbench/stc_top_tb_top.sv
/* Register and sleep sequence bench for the sleep timing block.
 Assumes short step parameters: poll 8, light entry 16, deep entry 32. */
`timescale 1ns/1ps
`default_nettype none
module stc_top_tb_top;
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   logic motion = 1'b1;
   logic psel, penable, pwrite, pready, pslverr, deep_sleep, poll_wake, wake_event, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0] operation_phase;
   int num_errors = 0, checks_done = 0, n;
   always #4 ref_clk = ~ref_clk;
   stc_top #(.POLL_STEP_CYC(32'h8), .L_ENTRY_STEP_CYC(32'h10), .D_ENTRY_STEP_CYC(32'h20))
   stc_top_i (.ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .motion(motion), .operation_phase(operation_phase),
      .deep_sleep(deep_sleep), .poll_wake(poll_wake), .wake_event(wake_event));
   stc_apb_host stc_apb_host_i (.ref_clk(ref_clk), .pready(pready), .pslverr(pslverr),
      .prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata));
   task report_and_stop;
      $display("errors=%0d checks=%0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task acc(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] x,
      input logic e);
      stc_apb_host_i.xfer(w, a, d, rd, err);
      if (stc_apb_host_i.to >= 50) begin
         num_errors++;
         report_and_stop();
      end
      if (!w) chk(rd, x);
      chk(err, e);
   endtask
   // Counts clocks until phase asleep (0), a poll (1) or a wake (2)
   task await(input int s);
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (!(s == 0 ? operation_phase === 3'h4 : s == 1 ? poll_wake === 1'b1 :
         wake_event === 1'b1) && n < 500);
      if (n >= 500) begin
         num_errors++;
         report_and_stop();
      end
   endtask
   initial begin
      repeat (6) @(posedge ref_clk);
      rstn <= 1'b1;
      repeat (3) @(posedge ref_clk);
      acc(1'h0, 12'h024, 32'h0, 32'h0, 1'h0);
      acc(1'h0, 12'h028, 32'h0, 32'h72, 1'h0);
      acc(1'h0, 12'h02C, 32'h0, 32'h10, 1'h0);
      acc(1'h0, 12'h040, 32'h0, 32'h1, 1'h0);
      acc(1'h1, 12'h028, 32'h12, 32'h0, 1'h1);
      acc(1'h0, 12'h028, 32'h0, 32'h72, 1'h0);
      acc(1'h0, 12'h0FC, 32'h0, 32'h0, 1'h1);
      acc(1'h1, 12'h024, 32'h5A, 32'h0, 1'h0);
      acc(1'h1, 12'h028, 32'h12, 32'h0, 1'h0);
      acc(1'h1, 12'h02C, 32'h20, 32'h0, 1'h0);
      acc(1'h0, 12'h028, 32'h0, 32'h12, 1'h0);
      chk(operation_phase, 32'h0);
      // Sleep disabled: no motion must not start light sleep entry
      acc(1'h1, 12'h040, 32'h0, 32'h0, 1'h0);
      motion <= 1'b0;
      repeat (8) @(posedge ref_clk);
      chk(operation_phase, 32'h0);
      acc(1'h1, 12'h040, 32'h1, 32'h0, 1'h0);
      repeat (4) @(posedge ref_clk);
      chk(operation_phase, 32'h1);
      await(0);
      chk(n + 4 >= 48 && n + 4 <= 52, 1'h1);
      chk(deep_sleep, 32'h0);
      motion <= 1'b1;
      await(1);
      chk(n >= 16 && n <= 20, 1'h1);
      chk(wake_event, 32'h1);
      repeat (2) @(posedge ref_clk);
      chk(operation_phase, 32'h0);
      // No motion at the poll: entry into deep sleep, then wake on motion
      motion <= 1'b0;
      await(0);
      chk(n >= 48 && n <= 54, 1'h1);
      await(1);
      chk(n >= 16 && n <= 20, 1'h1);
      chk(wake_event, 32'h0);
      @(posedge ref_clk);
      chk(operation_phase, 32'h2);
      await(0);
      chk(n >= 32 && n <= 36, 1'h1);
      chk(deep_sleep, 32'h1);
      acc(1'h0, 12'h044, 32'h0, 32'hC, 1'h0);
      motion <= 1'b1;
      await(2);
      chk(n <= 4, 1'h1);
      repeat (2) @(posedge ref_clk);
      chk(operation_phase, 32'h0);
      report_and_stop();
   end
endmodule
`default_nettype wire
